// ===== fwrs_map.vh
// constants for the flash write/reset/status host controller
`ifndef FWRS_MAP_VH
`define FWRS_MAP_VH
`define FWRS_REG_CTRL      4'h0
`define FWRS_REG_ADDR      4'h4
`define FWRS_REG_DATA      4'h8
`define FWRS_REG_STAT      4'hC
`define FWRS_CTRL_GO       0
`define FWRS_CTRL_RD       1
`define FWRS_CTRL_BANK1    2
`define FWRS_CTRL_RST      3
`define FWRS_CTRL_POLLG    4
`define FWRS_CTRL_POLL     5
`define FWRS_STAT_BUSY     0
`define FWRS_STAT_DONE     1
`define FWRS_STAT_RB       2
`define FWRS_STAT_TMO      3
`define FWRS_GLOBAL_BIT    15
`define FWRS_PART_BIT      7
`define FWRS_CLK_NS        8
`define FWRS_T_WP_NS       60
`define FWRS_T_WPH_NS      30
`define FWRS_T_ACC_NS      85
`define FWRS_T_RST_LOW_NS  100
`define FWRS_T_RST_REC_NS  150
`define FWRS_T_WR_REC_NS   30
`define FWRS_CYC_UP(ns)    (((ns) + `FWRS_CLK_NS - 1) / `FWRS_CLK_NS)
`endif

// ===== fwrs_host.v
// host controller driving a partitioned parallel nor flash from wishbone
//
// Function
// RULE1 - write framed by enable or write strobe
// RULE2 - pulse from last fall to first rise
// RULE3 - partition ready drops after command write
// RULE4 - ready/busy low within 100 ns
// RULE5 - wait 150 ns after reset release
// RULE6 - hold reset low at least 100 ns
// RULE7 - busy reset completes within 22 us
// RULE8 - idle reset completes within 100 ns
// RULE9 - reset low 100 ns at power-up
// RULE10 - data valid after reset recovery delay
// RULE11 - program suspend ready within 10 us
// RULE12 - erase suspend ready within 20 us
// RULE13 - 500 us between resume and suspend
// RULE14 - word program time limits
// RULE15 - parameter block erase within 4 s
// RULE16 - main block erase within 5 s
// RULE17 - one-time program uses bank 0 enable
// RULE18 - avoid bank 1 one-time area
// RULE19 - global ready bit set when all ready
// RULE20 - partition ready bit follows addressed partition
// RULE21 - partition ready does not mean engine free
// RULE22 - poll global bit when timing unmet
// RULE23 - status reads use ordinary read timing
// RULE24 - poll ready before next operation
`timescale 1ns/10ps
`include "fwrs_map.vh"
module fwrs_host #(
	parameter AW          = 23,
	parameter POLL_LIMIT  = 32'h0FFFFFFF
) (
	// system
	input  wire          clk,
	input  wire          rst,
	// wishbone slave
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [3:0]    wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	// flash pins
	output reg  [AW-1:0] flash_addr,
	input  wire [15:0]   flash_dq_i,
	output reg  [15:0]   flash_dq_o,
	output reg           flash_dq_oe,
	output reg           bank0_enable_n,
	output reg           bank1_enable_n,
	output reg           flash_we_n,
	output reg           flash_oe_n,
	output reg           flash_rst_n,
	input  wire          ready_busy_out_n
);
	localparam C_WP   = `FWRS_CYC_UP(`FWRS_T_WP_NS);
	localparam C_WPH  = `FWRS_CYC_UP(`FWRS_T_WPH_NS);
	localparam C_ACC  = `FWRS_CYC_UP(`FWRS_T_ACC_NS + `FWRS_T_WR_REC_NS);
	localparam C_RLOW = `FWRS_CYC_UP(`FWRS_T_RST_LOW_NS);
	localparam C_RREC = `FWRS_CYC_UP(`FWRS_T_RST_REC_NS);

	localparam S_IDLE  = 6'b000001;
	localparam S_WLOW  = 6'b000010;
	localparam S_WHIGH = 6'b000100;
	localparam S_READ  = 6'b001000;
	localparam S_RLOW  = 6'b010000;
	localparam S_RREC  = 6'b100000;

	reg [5:0]    state_r;
	reg [31:0]   cnt_r;
	reg [31:0]   poll_cnt_r;
	reg [AW-1:0] addr_r;
	reg [15:0]   wdata_r;
	reg [15:0]   rdata_r;
	reg          rd_r;
	reg          bank1_r;
	reg          poll_r;
	reg          pollg_r;
	reg          done_r;
	reg          tmo_r;
	wire         bus_req;
	wire         go_wr;
	wire         rdy_bit;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign go_wr   = bus_req & wb_we_i & (wb_adr_i == `FWRS_REG_CTRL) & wb_sel_i[0];
	// polled bit: global when the read timing cannot be met
	assign rdy_bit = pollg_r ? flash_dq_i[`FWRS_GLOBAL_BIT]
		: flash_dq_i[`FWRS_PART_BIT]; // see RULE22 see RULE21

	function [31:0] rd_mux;
		input [3:0] a;
		begin
			case (a)
				`FWRS_REG_ADDR: rd_mux = {{(32-AW){1'b0}}, addr_r};
				`FWRS_REG_DATA: rd_mux = {16'h0000, rdata_r};
				`FWRS_REG_STAT: rd_mux = {28'h0000000, tmo_r, ~ready_busy_out_n,
					done_r, ~state_r[0]};
				default:        rd_mux = 32'h00000000;
			endcase
		end
	endfunction

	// wishbone slave, one wait-free ack
	always @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			addr_r   <= {AW{1'b0}};
			wdata_r  <= 16'h0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req)
				wb_dat_o <= rd_mux(wb_adr_i);
			if (bus_req & wb_we_i & state_r[0]) begin
				if (wb_adr_i == `FWRS_REG_ADDR)
					addr_r <= wb_dat_i[AW-1:0];
				if (wb_adr_i == `FWRS_REG_DATA)
					wdata_r <= wb_dat_i[15:0];
			end
		end
	end

	// flash sequencer
	always @(posedge clk) begin
		if (rst) begin
			state_r        <= S_RLOW;
			cnt_r          <= 32'h00000000;
			poll_cnt_r     <= 32'h00000000;
			rdata_r        <= 16'h0000;
			rd_r           <= 1'b0;
			bank1_r        <= 1'b0;
			poll_r         <= 1'b0;
			pollg_r        <= 1'b0;
			done_r         <= 1'b0;
			tmo_r          <= 1'b0;
			flash_addr     <= {AW{1'b0}};
			flash_dq_o     <= 16'h0000;
			flash_dq_oe    <= 1'b0;
			bank0_enable_n <= 1'b1;
			bank1_enable_n <= 1'b1;
			flash_we_n     <= 1'b1;
			flash_oe_n     <= 1'b1;
			flash_rst_n    <= 1'b0; // see RULE9
		end else begin
			case (state_r)
				S_IDLE: begin
					if (go_wr & wb_dat_i[`FWRS_CTRL_RST]) begin
						flash_rst_n <= 1'b0;
						done_r      <= 1'b0;
						cnt_r       <= 32'h00000000;
						state_r     <= S_RLOW;
					end else if (go_wr & wb_dat_i[`FWRS_CTRL_GO]) begin
						rd_r    <= wb_dat_i[`FWRS_CTRL_RD];
						bank1_r <= wb_dat_i[`FWRS_CTRL_BANK1]; // see RULE17 see RULE18
						poll_r  <= wb_dat_i[`FWRS_CTRL_POLL];
						pollg_r <= wb_dat_i[`FWRS_CTRL_POLLG];
						done_r  <= 1'b0;
						tmo_r   <= 1'b0;
						cnt_r   <= 32'h00000000;
						poll_cnt_r <= 32'h00000000;
						flash_addr <= addr_r;
						if (wb_dat_i[`FWRS_CTRL_RD] | wb_dat_i[`FWRS_CTRL_POLL]) begin
							state_r <= S_READ;
						end else begin
							flash_dq_o  <= wdata_r;
							flash_dq_oe <= 1'b1;
							state_r     <= S_WLOW;
						end
					end
				end
				S_WLOW: begin
					// enable and write strobe fall together; write strobe frames the pulse
					if (cnt_r == 32'h00000000) begin
						bank0_enable_n <= bank1_r;
						bank1_enable_n <= ~bank1_r;
						flash_we_n     <= 1'b0; // see RULE1 see RULE2
					end
					if (cnt_r == C_WP) begin
						flash_we_n <= 1'b1;
						cnt_r      <= 32'h00000000;
						state_r    <= S_WHIGH;
					end else begin
						cnt_r <= cnt_r + 32'h00000001;
					end
				end
				S_WHIGH: begin
					bank0_enable_n <= 1'b1;
					bank1_enable_n <= 1'b1;
					if (cnt_r == C_WPH) begin
						flash_dq_oe <= 1'b0;
						done_r      <= 1'b1;
						cnt_r       <= 32'h00000000;
						state_r     <= S_IDLE;
					end else begin
						cnt_r <= cnt_r + 32'h00000001;
					end
				end
				S_READ: begin
					// status reads use ordinary read timing; strobes stay high between polls
					if (cnt_r >= C_WPH) begin
						bank0_enable_n <= bank1_r;
						bank1_enable_n <= ~bank1_r;
						flash_oe_n     <= 1'b0; // see RULE23
					end
					// total cycles spent polling, for the timeout
					poll_cnt_r <= poll_cnt_r + 32'h00000001;
					if (cnt_r == C_WPH + C_ACC) begin
						rdata_r        <= flash_dq_i;
						bank0_enable_n <= 1'b1;
						bank1_enable_n <= 1'b1;
						flash_oe_n     <= 1'b1;
						if (poll_r & ~rdy_bit & ~tmo_r) begin
							// keep polling until ready or timed out before next operation
							cnt_r <= 32'h00000000; // see RULE24
							if (poll_cnt_r >= POLL_LIMIT)
								tmo_r <= 1'b1;
						end else begin
							done_r  <= 1'b1;
							cnt_r   <= 32'h00000000;
							state_r <= S_IDLE;
						end
					end else begin
						cnt_r <= cnt_r + 32'h00000001;
					end
				end
				S_RLOW: begin
					flash_rst_n <= 1'b0;
					if (cnt_r == C_RLOW) begin
						flash_rst_n <= 1'b1; // see RULE6
						cnt_r       <= 32'h00000000;
						state_r     <= S_RREC;
					end else begin
						cnt_r <= cnt_r + 32'h00000001;
					end
				end
				S_RREC: begin
					// no strobe until recovery has passed
					if (cnt_r == C_RREC) begin
						done_r  <= 1'b1; // see RULE5 see RULE10
						cnt_r   <= 32'h00000000;
						state_r <= S_IDLE;
					end else begin
						cnt_r <= cnt_r + 32'h00000001;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule // fwrs_host

// ===== fwrs_host_asserts.sv
// assertions on the flash host controller ports
`timescale 1ns/10ps
module fwrs_host_asserts (
	// clock, reset, bus
	input wire clk, rst, wb_cyc_i, wb_stb_i, wb_ack_o,
	// flash pins
	input wire flash_we_n, flash_oe_n, bank0_enable_n, bank1_enable_n, flash_rst_n, flash_dq_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since the flash reset pin was released
	reg [5:0] rec_r;
	always @(posedge clk) rec_r <= !flash_rst_n ? 6'h00 : rec_r + {5'h00, rec_r != 6'h3F};
	property p_rec; $fell(flash_we_n) |-> rec_r > 6'h12; endproperty
	a_rec: assert property (p_rec) else $error("strobe soon after reset");
	property p_rlow; $rose(flash_rst_n) |-> !$past(flash_rst_n, 12); endproperty
	a_rlow: assert property (p_rlow) else $error("reset pulse short");
	property p_wp; $fell(flash_we_n) |-> (!flash_we_n)[*8] ##1 flash_we_n; endproperty
	a_wp: assert property (p_wp) else $error("write pulse width");
	property p_frm; !flash_we_n |-> bank0_enable_n != bank1_enable_n; endproperty
	a_frm: assert property (p_frm) else $error("write without one enable");
	property p_dh; $rose(flash_we_n) |-> flash_dq_oe[*2]; endproperty
	a_dh: assert property (p_dh) else $error("data hold");
	property p_wr; $rose(flash_we_n) |-> flash_oe_n[*4]; endproperty
	a_wr: assert property (p_wr) else $error("write recovery");
	property p_rd; !flash_oe_n |-> flash_we_n && !flash_dq_oe; endproperty
	a_rd: assert property (p_rd) else $error("read while writing");
	property p_rhi; $rose(flash_oe_n) |-> flash_oe_n[*4]; endproperty
	a_rhi: assert property (p_rhi) else $error("status read gap short");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus ack");
endmodule // fwrs_host_asserts
bind fwrs_host fwrs_host_asserts u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
	.bank0_enable_n(bank0_enable_n), .bank1_enable_n(bank1_enable_n),
	.flash_rst_n(flash_rst_n), .flash_dq_oe(flash_dq_oe));

// ===== fwrs_flash_model.sv
// behavioural flash device answering the host controller
`timescale 1ns/10ps
module fwrs_flash_model #(
	parameter BUSY_NS = 2000
) (
	input wire b0_n, b1_n, we_n, oe_n, rst_n,
	output wire [15:0] dq,
	output wire rb_n
);
	reg busy_r = 1'b0;
	reg [15:0] last_r = 16'h0000;
	wire sel = !(b0_n && b1_n);
	wire [15:0] word = {~busy_r, 7'h00, ~busy_r, 7'h00};
	always @(posedge we_n) if (sel && rst_n) begin
		busy_r = 1'b1;
		#(BUSY_NS) busy_r = 1'b0;
	end
	always @(negedge rst_n) #50 busy_r = 1'b0;
	always @* if (sel && !oe_n) last_r = word;
	// released bus shows the inverse of the last word
	assign dq = (sel && !oe_n) ? word : ~last_r;
	assign #50 rb_n = ~busy_r;
endmodule // fwrs_flash_model

// ===== fwrs_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
module fwrs_host_tb;
	reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
	reg [3:0] adr = 4'h0;
	reg [31:0] dat = 32'h0, q;
	wire [31:0] rd;
	wire ack, oe, b0, b1, wen, oen, fr, rb;
	wire [22:0] fa;
	wire [15:0] dqo, dqi;
	int miscompares = 0, checks = 0;
	reg [15:0] wr_d = 16'h0000;
	reg [22:0] wr_a = 23'h000000;
	reg [1:0] wr_en = 2'h0;
	// what the flash saw at the end of each write pulse
	always @(posedge wen) begin
		wr_d = dqo;
		wr_a = fa;
		wr_en = {b0, b1};
	end
	always #4 clk = ~clk;
	fwrs_host #(.POLL_LIMIT(32'h00000020)) u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(rd), .wb_ack_o(ack), .flash_addr(fa), .flash_dq_i(dqi), .flash_dq_o(dqo),
		.flash_dq_oe(oe), .bank0_enable_n(b0), .bank1_enable_n(b1), .flash_we_n(wen),
		.flash_oe_n(oen), .flash_rst_n(fr), .ready_busy_out_n(rb));
	fwrs_flash_model u_mem (.b0_n(b0), .b1_n(b1), .we_n(wen), .oe_n(oen), .rst_n(fr),
		.dq(dqi), .rb_n(rb));
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		@(posedge clk);
	endtask
	task st(input logic [31:0] e);
		do wb(1'b0, 4'hC, 32'h0); while (q[0] !== 1'b0);
		chk(q & 32'hF, e);
	endtask
	task stw(input logic [31:0] e);
		repeat (24) @(posedge clk);
		st(e);
	endtask
	task rdd(input logic [31:0] e);
		wb(1'b0, 4'h8, 32'h0);
		chk(q, e);
	endtask
	task t_regs;
		st(32'h2);
		wb(1'b0, 4'h0, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, 4'h1, 32'hFFFFFFFF);
		wb(1'b0, 4'h1, 32'h0);
		chk(q, 32'h0);
		$display("register test ends");
	endtask
	task t_ops(input logic [31:0] m);
		wb(1'b1, 4'h4, 32'h00000123);
		wb(1'b1, 4'h8, 32'h0000A5C3);
		wb(1'b1, 4'h0, m | 32'h1);
		stw(32'h6);
		chk({16'h0000, wr_d}, 32'h0000A5C3);
		chk({9'h000, wr_a}, 32'h00000123);
		chk({30'h00000000, wr_en}, {30'h00000000, m[2], ~m[2]});
		wb(1'b1, 4'h0, m | 32'h3);
		st(32'h6);
		rdd(32'h0);
		wb(1'b1, 4'h0, m | 32'h21);
		st(32'hE);
		rdd(32'h0);
		do wb(1'b0, 4'hC, 32'h0); while (q[2] !== 1'b0);
		wb(1'b1, 4'h0, m | 32'h21);
		st(32'h2);
		rdd(32'h8080);
		$display("operation test ends");
	endtask
	task t_reset;
		wb(1'b1, 4'h0, 32'h1);
		stw(32'h6);
		wb(1'b1, 4'h0, 32'h9);
		st(32'h2);
		wb(1'b1, 4'h0, 32'h3);
		st(32'h2);
		rdd(32'h8080);
		$display("reset test ends");
	endtask
	task print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_ops(32'h0);
		t_ops(32'h14);
		t_reset;
		print_verdict;
	end
endmodule // fwrs_host_tb
